// >>> pkg/mbdc_pkg.sv
// Package for the motion block disable controller: types, encodings, reset values
`default_nettype none
package mbdc_pkg;
    // Output telegram function of one output
    typedef enum logic [2:0] {
        MBDC_FN_SWITCH    = 3'h0,
        MBDC_FN_STAIR     = 3'h1,
        MBDC_FN_FORCED    = 3'h2,
        MBDC_FN_DIM       = 3'h3,
        MBDC_FN_SCENE     = 3'h4,
        MBDC_FN_TEMP      = 3'h5,
        MBDC_FN_BRIGHT    = 3'h6,
        MBDC_FN_OPMODE    = 3'h7
    } mbdc_func_e;

    // Forced position values
    typedef enum logic [1:0] {
        MBDC_FORCE_ON  = 2'h0,
        MBDC_FORCE_OFF = 2'h1,
        MBDC_FORCE_INA = 2'h2
    } mbdc_force_e;

    // Room controller operating modes
    typedef enum logic [2:0] {
        MBDC_OM_AUTO    = 3'h0,
        MBDC_OM_COMFORT = 3'h1,
        MBDC_OM_STANDBY = 3'h2,
        MBDC_OM_NIGHT   = 3'h3,
        MBDC_OM_FROST   = 3'h4
    } mbdc_opmode_e;

    // End-of-disabling behaviour
    typedef enum logic [1:0] {
        MBDC_END_SILENT  = 2'h0,
        MBDC_END_AS_END  = 2'h1,
        MBDC_END_AS_START= 2'h2,
        MBDC_END_RESTORE = 2'h3
    } mbdc_endbeh_e;

    // Application type
    typedef enum logic [1:0] {
        MBDC_APP_SINGLE = 2'h0,
        MBDC_APP_MAIN   = 2'h1,
        MBDC_APP_EXT    = 2'h2
    } mbdc_apptype_e;

    // Controller states, Gray along idle -> disabled -> resume
    typedef enum logic [1:0] {
        MBDC_ST_ENABLED  = 2'h0,
        MBDC_ST_DISABLED = 2'h1,
        MBDC_ST_RESUME   = 2'h3
    } mbdc_state_e;

    // Telegram start-of-disabling configuration of one output
    typedef struct packed {
        mbdc_func_e   func;
        logic         switch_on;
        mbdc_force_e  force_pos;
        logic [6:0]   dim_pct;
        logic [5:0]   scene;
        logic [5:0]   temp_c;
        logic [5:0]   bright_step;
        mbdc_opmode_e opmode;
    } mbdc_outcfg_s;

    // Telegram issued on one output
    typedef struct packed {
        mbdc_func_e  func;
        logic [10:0] value;
    } mbdc_tgram_s;

    // Reset / default values, limits and constants
    localparam logic [6:0] MBDC_DIM_DEF      = 7'h00;
    localparam logic [6:0] MBDC_DIM_MAX      = 7'h64;
    localparam logic [5:0] MBDC_TEMP_DEF     = 6'h15;
    localparam logic [5:0] MBDC_TEMP_MAX     = 6'h28;
    localparam logic [5:0] MBDC_BRIGHT_DEF   = 6'h0F;
    localparam logic [5:0] MBDC_BRIGHT_MAX   = 6'h28;
    localparam logic [5:0] MBDC_LUX_STEP     = 6'h32;
    localparam int         MBDC_NUM_OUT      = 2;
    localparam logic [1:0] MBDC_SYNC_RST     = 2'h0;
endpackage
`default_nettype wire

// >>> hw/mbdc_ctrl.sv
// Disable (interlock) controller for one motion detection function block
//
// Contract
// [R1] Disable input polarity selectable
// [R2] Single/main types may send start telegrams
// [R3] Alert or extension: no start telegram
// [R4] Entry stops and resets all delays
// [R5] Entry freezes current motion state
// [R6] Disable-without-telegram transmits nothing
// [R7] Disable-with-telegram sends configured telegram
// [R8] Separate start settings per output
// [R9] Switch/staircase send ON or OFF
// [R10] Forced: active ON, active OFF, inactive
// [R11] Dimming value 0..100 percent
// [R12] Temperature 0..40 degrees, default 21
// [R13] Brightness 0..2000 lux, 50 lux steps
// [R14] Operating mode, standby default
// [R15] One common end behaviour for outputs
// [R16] Silent end: no motion, no telegram
// [R17] Extension or detector forces silent end
// [R18] End-as-end: end reaction, no motion
// [R19] Lockout gates new detection afterwards
// [R20] End-as-start: simulated detection, delay starts
// [R21] Restore uses frozen motion state
// [R22] Act only on decoded input changes
`default_nettype none
module mbdc_ctrl (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  disable_pin,       // Raw disabling input, asynchronous
    input  wire logic                  polarity_inv,      // 1: value 0 disables
    input  wire mbdc_pkg::mbdc_apptype_e app_type,
    input  wire logic                  alert_app,         // Alert operation application
    input  wire logic                  detector_app,      // Detector application
    input  wire logic                  start_tgram_en,    // Disable with telegram
    input  wire mbdc_pkg::mbdc_endbeh_e end_beh,
    input  wire mbdc_pkg::mbdc_outcfg_s out_cfg_1,
    input  wire mbdc_pkg::mbdc_outcfg_s out_cfg_2,
    input  wire logic                  motion_active,     // Live motion state of the block
    input  wire logic                  lockout_done,      // Lockout elapsed or not enabled
    output logic                       interlocked,
    output logic                       delay_reset,       // Pulse: stop and clear all delays
    output logic                       motion_frozen,
    output logic                       tgram_valid_1,
    output mbdc_pkg::mbdc_tgram_s      tgram_1,
    output logic                       tgram_valid_2,
    output mbdc_pkg::mbdc_tgram_s      tgram_2,
    output logic                       det_start,         // Pulse: run start-of-detection reaction
    output logic                       det_end,           // Pulse: run end-of-detection reaction
    output logic                       force_no_motion,   // Pulse: motion state to no motion
    output logic                       detect_ready       // New detection may be accepted
);

    // Build a telegram from an output's start-of-disabling configuration
    function automatic mbdc_pkg::mbdc_tgram_s build_tgram(input mbdc_pkg::mbdc_outcfg_s c);
        mbdc_pkg::mbdc_tgram_s t;
        t.func  = c.func;
        t.value = 11'h000;
        unique case (c.func)
            mbdc_pkg::MBDC_FN_SWITCH,
            mbdc_pkg::MBDC_FN_STAIR:  t.value = {10'h000, c.switch_on}; // [R9]
            mbdc_pkg::MBDC_FN_FORCED: t.value = {9'h000, c.force_pos};  // [R10]
            mbdc_pkg::MBDC_FN_DIM:    t.value = {4'h0, (c.dim_pct > mbdc_pkg::MBDC_DIM_MAX)
                                                     ? mbdc_pkg::MBDC_DIM_MAX : c.dim_pct}; // [R11]
            mbdc_pkg::MBDC_FN_SCENE:  t.value = {5'h00, c.scene};
            mbdc_pkg::MBDC_FN_TEMP:   t.value = {5'h00, (c.temp_c > mbdc_pkg::MBDC_TEMP_MAX)
                                                     ? mbdc_pkg::MBDC_TEMP_MAX : c.temp_c}; // [R12]
            // Both factors widened first: a 6-bit product would wrap long before 2000 lux
            mbdc_pkg::MBDC_FN_BRIGHT: t.value = 11'((c.bright_step > mbdc_pkg::MBDC_BRIGHT_MAX)
                                                     ? mbdc_pkg::MBDC_BRIGHT_MAX : c.bright_step)
                                                * 11'(mbdc_pkg::MBDC_LUX_STEP); // [R13]
            mbdc_pkg::MBDC_FN_OPMODE: t.value = {8'h00, c.opmode};      // [R14]
        endcase
        return t;
    endfunction

    // Three-stage synchroniser on the disabling pin
    logic [2:0] sync_q;
    logic [2:0] next_sync_q;
    logic       dis_level;      // Filtered, polarity-decoded level
    logic       next_dis_level;

    // Decode: stages two and three must agree before a change counts
    always_comb begin
        next_sync_q    = {sync_q[1:0], disable_pin};
        next_dis_level = dis_level;
        if (sync_q[1] == sync_q[2]) begin
            next_dis_level = sync_q[2] ^ polarity_inv; // [R1]
        end
    end

    // Synchroniser registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync_q    <= 3'h0;
            dis_level <= 1'b0;
        end else begin
            sync_q    <= next_sync_q;
            dis_level <= next_dis_level;
        end
    end

    // Controller state and outputs
    mbdc_pkg::mbdc_state_e state;
    mbdc_pkg::mbdc_state_e next_state;
    mbdc_pkg::mbdc_tgram_s next_tgram_1;
    mbdc_pkg::mbdc_tgram_s next_tgram_2;
    logic next_interlocked;
    logic next_delay_reset;
    logic next_motion_frozen;
    logic next_tv1;
    logic next_tv2;
    logic next_det_start;
    logic next_det_end;
    logic next_force_nm;
    logic next_detect_ready;
    logic start_tg_allowed;  // Start telegrams permitted for this application
    logic silent_forced;     // Silent end forced by application
    mbdc_pkg::mbdc_endbeh_e eff_end;

    // Application gating of the configured behaviour
    always_comb begin
        start_tg_allowed = start_tgram_en && !alert_app
                           && (app_type != mbdc_pkg::MBDC_APP_EXT); // [R2] [R3]
        silent_forced    = (app_type == mbdc_pkg::MBDC_APP_EXT) || detector_app; // [R17]
        eff_end          = silent_forced ? mbdc_pkg::MBDC_END_SILENT : end_beh;  // [R15]
    end

    // Next-state logic; acts only on changes of the decoded level
    always_comb begin
        next_state         = state;
        next_interlocked   = interlocked;
        next_motion_frozen = motion_frozen;
        next_delay_reset   = 1'b0;
        next_tv1           = 1'b0;
        next_tv2           = 1'b0;
        next_tgram_1       = tgram_1;
        next_tgram_2       = tgram_2;
        next_det_start     = 1'b0;
        next_det_end       = 1'b0;
        next_force_nm      = 1'b0;
        next_detect_ready  = detect_ready;
        unique case (state)
            // Enabled: wait for a change to disable
            mbdc_pkg::MBDC_ST_ENABLED: begin
                if (!detect_ready && lockout_done) begin
                    next_detect_ready = 1'b1; // [R19]
                end
                if (dis_level) begin // [R22]
                    next_state         = mbdc_pkg::MBDC_ST_DISABLED;
                    next_interlocked   = 1'b1;
                    next_delay_reset   = 1'b1;          // [R4]
                    next_motion_frozen = motion_active; // [R5]
                    next_detect_ready  = 1'b0;
                    if (start_tg_allowed) begin         // [R7]
                        next_tv1     = 1'b1;            // [R8]
                        next_tv2     = 1'b1;
                        next_tgram_1 = build_tgram(out_cfg_1);
                        next_tgram_2 = build_tgram(out_cfg_2);
                    end                                 // [R6] otherwise silent
                end
            end
            // Disabled: wait for a change to enable
            mbdc_pkg::MBDC_ST_DISABLED: begin
                if (!dis_level) begin // [R22]
                    next_state = mbdc_pkg::MBDC_ST_RESUME;
                end
            end
            // Resume: apply end behaviour once and release the block in the same cycle
            mbdc_pkg::MBDC_ST_RESUME: begin
                next_state       = mbdc_pkg::MBDC_ST_ENABLED;
                next_interlocked = 1'b0;
                unique case (eff_end)
                    mbdc_pkg::MBDC_END_SILENT: begin
                        next_force_nm     = 1'b1; // [R16]
                        next_detect_ready = 1'b1;
                    end
                    mbdc_pkg::MBDC_END_AS_END: begin
                        next_det_end  = 1'b1; // [R18]
                        next_force_nm = 1'b1;
                    end
                    mbdc_pkg::MBDC_END_AS_START: begin
                        next_det_start    = 1'b1; // [R20]
                        next_detect_ready = 1'b1;
                    end
                    mbdc_pkg::MBDC_END_RESTORE: begin
                        if (motion_frozen) begin // [R21]
                            next_det_start    = 1'b1;
                            next_detect_ready = 1'b1;
                        end else begin
                            next_det_end  = 1'b1;
                            next_force_nm = 1'b1;
                        end
                    end
                endcase
            end
            default: begin
                next_state = mbdc_pkg::MBDC_ST_ENABLED;
            end
        endcase
    end

    // Controller registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state         <= mbdc_pkg::MBDC_ST_ENABLED;
            interlocked   <= 1'b0;
            delay_reset   <= 1'b0;
            motion_frozen <= 1'b0;
            tgram_valid_1 <= 1'b0;
            tgram_valid_2 <= 1'b0;
            tgram_1       <= '0;
            tgram_2       <= '0;
            det_start     <= 1'b0;
            det_end       <= 1'b0;
            force_no_motion <= 1'b0;
            detect_ready  <= 1'b1;
        end else begin
            state         <= next_state;
            interlocked   <= next_interlocked;
            delay_reset   <= next_delay_reset;
            motion_frozen <= next_motion_frozen;
            tgram_valid_1 <= next_tv1;
            tgram_valid_2 <= next_tv2;
            tgram_1       <= next_tgram_1;
            tgram_2       <= next_tgram_2;
            det_start     <= next_det_start;
            det_end       <= next_det_end;
            force_no_motion <= next_force_nm;
            detect_ready  <= next_detect_ready;
        end
    end

endmodule
`default_nettype wire

// >>> tb/mbdc_actuator.sv
// Model of one bus actuator that keeps the last telegram it received
`default_nettype none
module mbdc_actuator (
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  tg_valid,  // One-cycle telegram strobe
    input  wire mbdc_pkg::mbdc_tgram_s tg,        // Telegram content
    output mbdc_pkg::mbdc_tgram_s      last_rx    // Last telegram taken
);
    timeunit 1ns;
    timeprecision 1ps;
    // Takes a telegram only in its valid cycle, so a stale value never counts twice
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_rx <= '0;
        end else if (tg_valid) begin
            last_rx <= tg;
        end
    end
endmodule
`default_nettype wire

// >>> tb/mbdc_ctrl_assertions.sv
// Checker of the disable controller port timing
`default_nettype none
module mbdc_ctrl_chk (
    input wire logic                   core_clk,
    input wire logic                   sys_rst,
    input wire mbdc_pkg::mbdc_apptype_e app_type,
    input wire logic                   alert_app,
    input wire logic                   detector_app,
    input wire logic                   start_tgram_en,
    input wire logic                   motion_active,
    input wire logic                   lockout_done,
    input wire logic                   interlocked,
    input wire logic                   delay_reset,
    input wire logic                   motion_frozen,
    input wire logic                   tgram_valid_1,
    input wire logic                   tgram_valid_2,
    input wire logic                   det_start,
    input wire logic                   det_end,
    input wire logic                   force_no_motion,
    input wire logic                   detect_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Start telegram permitted by setting and application
    logic tg_ok;
    // Extension or detector forces the silent end
    logic silent;
    assign tg_ok = start_tgram_en && !alert_app && (app_type != mbdc_pkg::MBDC_APP_EXT);
    assign silent = (app_type == mbdc_pkg::MBDC_APP_EXT) || detector_app;
    a_entry_clears: assert property ($rose(interlocked) |-> delay_reset)
        else $error("delay clear missing at entry");
    a_clear_only_entry: assert property (delay_reset |-> $rose(interlocked))
        else $error("delay clear outside entry");
    a_freeze_capture: assert property ($rose(interlocked) |-> motion_frozen == $past(motion_active))
        else $error("motion state not captured");
    a_freeze_hold: assert property (interlocked && $past(interlocked) |-> $stable(motion_frozen))
        else $error("frozen state changed");
    a_tgram_gate: assert property (tgram_valid_1 || tgram_valid_2 |-> $rose(interlocked) && $past(tg_ok))
        else $error("telegram where none allowed");
    a_tgram_sent: assert property ($rose(interlocked) && $past(tg_ok) |-> tgram_valid_1 && tgram_valid_2)
        else $error("start telegram missing");
    a_forced_silent: assert property ($fell(interlocked) && $past(silent) |-> force_no_motion && !det_start && !det_end)
        else $error("silent end not forced");
    a_lockout_wait: assert property (det_end |-> !detect_ready)
        else $error("ready before lockout");
    a_lockout_release: assert property ($rose(lockout_done) && !interlocked |=> detect_ready)
        else $error("ready late after lockout");
    a_start_ready: assert property (det_start |-> detect_ready && !det_end && !force_no_motion)
        else $error("start reaction malformed");
    a_end_no_motion: assert property (det_end |-> force_no_motion)
        else $error("end reaction keeps motion");
endmodule
bind mbdc_ctrl mbdc_ctrl_chk u_chk (.*);
`default_nettype wire

// >>> tb/test_mbdc_ctrl.sv
// Bench for the disable controller with two actuator models
`default_nettype none
module test_mbdc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, sys_rst, pin, pol, alrt, detc, st_en, mot, lock;  // Driven inputs
    logic lck, drst, frz, v1, v2, ds, de, fnm, rdy;                    // Observed outputs
    mbdc_pkg::mbdc_apptype_e app;
    mbdc_pkg::mbdc_endbeh_e  eb;
    mbdc_pkg::mbdc_outcfg_s  c1, c2;
    mbdc_pkg::mbdc_tgram_s   t1, t2, r1, r2;
    logic [1:0]              ex;                                       // 0 silent, 1 end, 2 start
    int                      mismatches, checks_done, cyc, i;
    mbdc_ctrl dut (.core_clk(core_clk), .sys_rst(sys_rst), .disable_pin(pin), .polarity_inv(pol),
        .app_type(app), .alert_app(alrt), .detector_app(detc), .start_tgram_en(st_en), .end_beh(eb),
        .out_cfg_1(c1), .out_cfg_2(c2), .motion_active(mot), .lockout_done(lock), .interlocked(lck),
        .delay_reset(drst), .motion_frozen(frz), .tgram_valid_1(v1), .tgram_1(t1), .tgram_valid_2(v2),
        .tgram_2(t2), .det_start(ds), .det_end(de), .force_no_motion(fnm), .detect_ready(rdy));
    mbdc_actuator act1 (.core_clk(core_clk), .sys_rst(sys_rst), .tg_valid(v1), .tg(t1), .last_rx(r1));
    mbdc_actuator act2 (.core_clk(core_clk), .sys_rst(sys_rst), .tg_valid(v2), .tg(t2), .last_rx(r2));
    // Free-running 40 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard, well above the fewer than 200 cycles the sequence needs
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 3000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic final_report;
        if (mismatches == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Drive the pin for a decoded level and wait, bounded, for the block to follow
    task automatic go(input logic dis);
        int k;
        pin = dis ^ pol;
        for (k = 0; k < 20 && lck !== dis; k++) @(negedge core_clk);
        cmp(lck, dis);
    endtask
    // Expected telegram value of one output
    function automatic logic [10:0] ev(input mbdc_pkg::mbdc_outcfg_s c);
        case (c.func)
            mbdc_pkg::MBDC_FN_SWITCH, mbdc_pkg::MBDC_FN_STAIR: ev = 11'(c.switch_on);
            mbdc_pkg::MBDC_FN_FORCED: ev = 11'(c.force_pos);
            mbdc_pkg::MBDC_FN_DIM:    ev = 11'(c.dim_pct);
            mbdc_pkg::MBDC_FN_SCENE:  ev = 11'(c.scene);
            mbdc_pkg::MBDC_FN_TEMP:   ev = 11'(c.temp_c);
            mbdc_pkg::MBDC_FN_BRIGHT: ev = 11'(c.bright_step) * 11'h032;
            default:                  ev = 11'(c.opmode);
        endcase
    endfunction
    // One full disable and enable, checking entry and end reactions
    task automatic cycle(input logic tg, input logic [1:0] e);
        go(1'b1);
        cmp(drst, 1'b1);
        cmp(frz, mot);
        cmp(v1, tg);
        cmp(v2, tg);
        @(negedge core_clk);
        go(1'b0);
        cmp(fnm, e != 2'h2);
        cmp(de, e == 2'h1);
        cmp(ds, e == 2'h2);
        cmp(rdy, e != 2'h1);
        lock = 1'b1;
        repeat (2) @(negedge core_clk);
        cmp(rdy, 1'b1);
        lock = 1'b0;
    endtask
    initial begin
        {pin, pol, alrt, detc, mot, lock} = '0;
        st_en = 1'b1;
        app = mbdc_pkg::MBDC_APP_SINGLE;
        eb = mbdc_pkg::MBDC_END_SILENT;
        c1 = '{mbdc_pkg::MBDC_FN_SWITCH, 1'b1, mbdc_pkg::MBDC_FORCE_INA, 7'h64, 6'h05, 6'h15, 6'h0F,
               mbdc_pkg::MBDC_OM_STANDBY};
        c2 = '{mbdc_pkg::MBDC_FN_SWITCH, 1'b0, mbdc_pkg::MBDC_FORCE_OFF, 7'h00, 6'h3F, 6'h28, 6'h28,
               mbdc_pkg::MBDC_OM_FROST};
        sys_rst = 1'b1;
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        cmp(rdy, 1'b1);
        cmp(lck, 1'b0);
        // Every function on both outputs, every end setting, both frozen states
        for (i = 0; i < 8; i++) begin
            c1.func = mbdc_pkg::mbdc_func_e'(i);
            c2.func = mbdc_pkg::mbdc_func_e'(7 - i);
            eb = mbdc_pkg::mbdc_endbeh_e'(i % 4);
            mot = i[2];
            ex = (i % 4 == 3) ? (i[2] ? 2'h2 : 2'h1) : 2'(i % 4);
            cycle(1'b1, ex);
            cmp(r1, {c1.func, ev(c1)});
            cmp(r2, {c2.func, ev(c2)});
        end
        eb = mbdc_pkg::MBDC_END_AS_START;
        pol = 1'b1;
        st_en = 1'b0;
        cycle(1'b0, 2'h2);
        pol = 1'b0;
        st_en = 1'b1;
        alrt = 1'b1;
        cycle(1'b0, 2'h2);
        alrt = 1'b0;
        app = mbdc_pkg::MBDC_APP_EXT;
        cycle(1'b0, 2'h0);
        app = mbdc_pkg::MBDC_APP_MAIN;
        detc = 1'b1;
        cycle(1'b1, 2'h0);
        final_report();
    end
endmodule
`default_nettype wire
